/* File: hdl/eeprom_group_ecc.sv */
// Group ECC between the serial front end and the EEPROM array
// Contract
// [R1] ECC hidden from bus timing and acknowledges
// [R2] Four-byte groups, low two address bits
// [R3] Reads correct any single flipped bit
// [R4] Single byte writes keep group neighbours
// [R5] Partial writes rewrite whole group, new checks
// [R6] Host keeps group cycles under endurance
// [R7] One internal write cycle per instruction
// [R8] Host waits 2 ms after power-up
// [R9] Program after Stop, ignore requests meanwhile
// [R10] No address acknowledge while programming
// [R11] Hamming checks recomputed on each group write
`default_nettype none
module eeprom_group_ecc
   import eeprom_ecc_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = eeprom_ecc_pkg::WR_CYC // Busy time in clocks
)(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Read request from the front end
   input wire logic FE_RD_REQ,
   input wire logic [eeprom_ecc_pkg::ADDR_W-1:0] FE_RD_ADDR,
   output logic [7:0] FE_RD_DATA,
   output logic FE_RD_VALID,
   output logic FE_RD_FIXED,
   // Write bytes and Stop from the front end
   input wire logic FE_WR_STB,
   input wire logic [eeprom_ecc_pkg::ADDR_W-1:0] FE_WR_ADDR,
   input wire logic [7:0] FE_WR_DATA,
   input wire logic FE_WR_STOP,
   // Status toward the front end
   output logic FE_BUSY,
   output logic PROG_START,
   // Array port, one codeword per group
   output logic [eeprom_ecc_pkg::GRP_W-1:0] ARR_ADDR,
   output logic ARR_RD_EN,
   input wire logic [eeprom_ecc_pkg::CW_W-1:0] ARR_RD_WORD,
   output logic ARR_WR_EN,
   output logic [eeprom_ecc_pkg::CW_W-1:0] ARR_WR_WORD
);
   // ==========================================================
   // Declarations
   // ==========================================================
   prog_state_t st_r; // Programming sequencer
   logic [GIDX_W-1:0] grp_r; // Group under work within the page
   logic [PAGE_NUM_W-1:0] page_r; // Page of the pending write
   logic [7:0] pbuf_r [PAGE_BYTES]; // Received write bytes
   logic [PAGE_BYTES-1:0] mask_r; // Bytes written this instruction
   logic [31:0] cnt_r; // Clocks since programming began
   logic rd_s1_r; // Front-end read, array strobe cycle
   logic rd_s2_r; // Front-end read, array data cycle
   logic [LANE_W-1:0] lane1_r; // Byte lane of the read in flight
   logic [LANE_W-1:0] lane2_r;
   logic [GRP_W-1:0] arr_addr_r;
   logic arr_rd_en_r;
   logic arr_wr_en_r;
   logic [CW_W-1:0] arr_wr_word_r;
   logic [7:0] rd_data_r;
   logic rd_valid_r;
   logic rd_fixed_r;
   logic [DATA_W-1:0] fix_data; // Corrected group data
   logic fix_hit; // Single bit was repaired
   logic [GRP_BYTES-1:0] lane_mask; // Written lanes of this group
   logic [DATA_W-1:0] merged; // New bytes over old corrected ones
   logic rd_take; // Read accepted this cycle
   logic wr_take; // Write byte accepted this cycle
   logic hold_done; // Busy time has elapsed

   // ==========================================================
   // Corrector on the array read data
   // ==========================================================
   ecc_group_fix ecc_group_fix_i (
      .word(ARR_RD_WORD),
      .data(fix_data),
      .fixed(fix_hit),
      .bad()
   );

   // ==========================================================
   // Request gating
   // ==========================================================
   // Requests only count while idle; the front end also NACKs on busy
   assign FE_BUSY = (st_r != ST_IDLE); // R10
   assign rd_take = FE_RD_REQ && !FE_BUSY; // R9
   assign wr_take = FE_WR_STB && !FE_BUSY; // R9
   // One programming run per Stop, only when bytes arrived
   assign PROG_START = (st_r == ST_IDLE) && FE_WR_STOP && (|mask_r); // R7
   assign hold_done = (cnt_r >= 32'(WRITE_CYCLES - 1));
   assign lane_mask = mask_r[int'(grp_r) * GRP_BYTES +: GRP_BYTES];

   // Merge the fresh bytes over the corrected old group
   always_comb begin
      for (int i = 0; i < GRP_BYTES; i++) begin
         merged[8*i +: 8] = lane_mask[i] ?
            pbuf_r[int'(grp_r) * GRP_BYTES + i] : fix_data[8*i +: 8]; // R4
      end
   end

   // ==========================================================
   // Write collection
   // ==========================================================
   // Byte store, no reset needed as the mask qualifies it
   always_ff @(posedge CLK) begin
      if (wr_take) begin
         pbuf_r[FE_WR_ADDR[PAGE_IDX_W-1:0]] <= FE_WR_DATA;
      end
   end

   // Written-byte mask; page index wraps inside the page
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mask_r <= '0;
         page_r <= '0;
      end else if (st_r == ST_HOLD && hold_done) begin
         mask_r <= '0;
      end else if (wr_take) begin
         mask_r[FE_WR_ADDR[PAGE_IDX_W-1:0]] <= 1'b1;
         page_r <= FE_WR_ADDR[ADDR_W-1:PAGE_IDX_W];
      end
   end

   // ==========================================================
   // Programming sequencer
   // ==========================================================
   // Walks the 32 groups of the page, rewriting every touched one
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_r <= ST_IDLE;
         grp_r <= '0;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               if (PROG_START) begin // R9
                  st_r <= ST_SCAN;
                  grp_r <= '0;
               end
            end
            ST_SCAN: begin
               if (|lane_mask) begin // R5
                  st_r <= ST_RDWAIT;
               end else if (grp_r == LAST_GRP) begin
                  st_r <= ST_HOLD;
               end else begin
                  grp_r <= grp_r + 5'h1;
               end
            end
            ST_RDWAIT: begin
               st_r <= ST_MERGE;
            end
            ST_MERGE: begin
               if (grp_r == LAST_GRP) begin
                  st_r <= ST_HOLD;
               end else begin
                  grp_r <= grp_r + 5'h1;
                  st_r <= ST_SCAN;
               end
            end
            ST_HOLD: begin
               // Keeps the address NACKed for the full write time
               if (hold_done) begin // R10
                  st_r <= ST_IDLE;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Busy-time counter, runs from the Stop onward
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cnt_r <= '0;
      end else if (st_r == ST_IDLE) begin
         cnt_r <= '0;
      end else if (!hold_done) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // ==========================================================
   // Array port
   // ==========================================================
   // Shared port: front-end reads only while idle, so never in conflict
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         arr_rd_en_r <= 1'b0;
         arr_addr_r <= '0;
      end else if (rd_take) begin
         arr_rd_en_r <= 1'b1;
         arr_addr_r <= FE_RD_ADDR[ADDR_W-1:LANE_W]; // R2
      end else if (st_r == ST_SCAN && (|lane_mask)) begin
         arr_rd_en_r <= 1'b1;
         arr_addr_r <= {page_r, grp_r}; // R2
      end else begin
         arr_rd_en_r <= 1'b0;
      end
   end

   // Whole group rewritten with fresh check bits
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         arr_wr_en_r <= 1'b0;
         arr_wr_word_r <= '0;
      end else if (st_r == ST_MERGE) begin
         arr_wr_en_r <= 1'b1; // R5
         arr_wr_word_r <= ecc_enc_f(merged); // R11
      end else begin
         arr_wr_en_r <= 1'b0;
      end
   end

   assign ARR_ADDR = arr_addr_r;
   assign ARR_RD_EN = arr_rd_en_r;
   assign ARR_WR_EN = arr_wr_en_r;
   assign ARR_WR_WORD = arr_wr_word_r;

   // ==========================================================
   // Read return path
   // ==========================================================
   // Fixed three-clock latency whether or not a bit was repaired
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rd_s1_r <= 1'b0;
         rd_s2_r <= 1'b0;
         lane1_r <= '0;
         lane2_r <= '0;
         rd_valid_r <= 1'b0;
         rd_fixed_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         rd_s1_r <= rd_take;
         rd_s2_r <= rd_s1_r;
         lane1_r <= FE_RD_ADDR[LANE_W-1:0];
         lane2_r <= lane1_r;
         rd_valid_r <= rd_s2_r; // R1
         if (rd_s2_r) begin
            rd_data_r <= fix_data[8*int'(lane2_r) +: 8]; // R3
            rd_fixed_r <= fix_hit;
         end
      end
   end

   assign FE_RD_DATA = rd_data_r;
   assign FE_RD_VALID = rd_valid_r;
   assign FE_RD_FIXED = rd_fixed_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // True when every unwritten lane kept its corrected old byte
   function automatic logic keep_ok_f(input logic [DATA_W-1:0] nw,
         input logic [DATA_W-1:0] old, input logic [GRP_BYTES-1:0] m);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < GRP_BYTES; i++) begin
         if (!m[i] && nw[8*i +: 8] != old[8*i +: 8]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   rd_latency_a: assert property (rd_take |-> ##3 FE_RD_VALID) // R1
      else $error("read answer not three clocks after request");
   grp_addr_a: assert property ( // R2
      rd_take |=> ARR_RD_EN && ARR_ADDR == $past(FE_RD_ADDR[ADDR_W-1:LANE_W]))
      else $error("array group address wrong for read");
   rd_fix_a: assert property ( // R3
      rd_s2_r |=> FE_RD_FIXED == ($past(ecc_syn_f(ARR_RD_WORD)) inside {[6'h1:6'(CW_W)]}))
      else $error("correction flag does not match syndrome");
   keep_bytes_a: assert property ( // R4
      st_r == ST_MERGE |=> keep_ok_f(ecc_data_f(ARR_WR_WORD), $past(fix_data), $past(lane_mask)))
      else $error("unwritten byte of group changed");
   group_rewrite_a: assert property ( // R5
      st_r == ST_SCAN && (|lane_mask) |-> ##1 ARR_RD_EN ##2 ARR_WR_EN)
      else $error("touched group not rewritten");
   one_start_a: assert property (PROG_START |=> FE_BUSY && !PROG_START) // R7
      else $error("programming start not single");
   busy_ignore_a: assert property (FE_BUSY && st_r != ST_HOLD |=> $stable(mask_r)) // R9
      else $error("write byte taken while programming");
   busy_hold_a: assert property (st_r == ST_HOLD && !hold_done |=> FE_BUSY) // R10
      else $error("busy dropped before write time");
   code_clean_a: assert property (ARR_WR_EN |-> ecc_syn_f(ARR_WR_WORD) == 6'h0) // R11
      else $error("written codeword has nonzero syndrome");

   rd_fixed_c: cover property (rd_s2_r && fix_hit);
   byte_write_c: cover property (st_r == ST_MERGE && $countones(lane_mask) == 1);
   prog_done_c: cover property ($fell(FE_BUSY));
   busy_read_c: cover property (FE_RD_REQ && FE_BUSY);
endmodule
`default_nettype wire

/* File: include/eeprom_ecc_pkg.sv */
// Constants, state encoding and Hamming helpers for the group ECC block
`default_nettype none
package eeprom_ecc_pkg;
   // ==========================================================
   // Geometry
   // ==========================================================
   localparam int ADDR_W = 14;        // Byte address width, 16K bytes
   localparam int LANE_W = 2;         // Byte-in-group select bits
   localparam int GRP_BYTES = 4;      // Bytes per protection group
   localparam int GRP_W = 12;         // Group index width in the array
   localparam int PAGE_IDX_W = 7;     // Byte index within a page
   localparam int PAGE_NUM_W = 7;     // Page number width
   localparam int PAGE_BYTES = 128;   // Bytes per page
   localparam int GIDX_W = 5;         // Group index within a page
   localparam logic [GIDX_W-1:0] LAST_GRP = 5'h1f; // Last group of a page
   localparam int DATA_W = 32;        // Data bits per group
   localparam int CW_W = 38;          // Stored Hamming codeword width
   localparam int CHK_W = 6;          // Check bits per group

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 100;     // 10 MHz core clock
   localparam int T_WR_NS = 5000000;       // Longest write cycle, 5 ms
   // Longest time, so round down
   localparam int WR_CYC = T_WR_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Programming sequencer states (Gray along the path)
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SCAN = 3'h1,
      ST_RDWAIT = 3'h3,
      ST_MERGE = 3'h2,
      ST_HOLD = 3'h6
   } prog_state_t;

   // ==========================================================
   // Hamming code, position p+1 holds codeword bit p
   // ==========================================================
   // Syndrome: zero for a clean word, else the failing position
   function automatic logic [CHK_W-1:0] ecc_syn_f(input logic [CW_W-1:0] cw);
      logic [CHK_W-1:0] s;
      s = '0;
      for (int p = 1; p <= CW_W; p++) begin
         if (cw[p-1]) begin
            s = s ^ CHK_W'(p);
         end
      end
      return s;
   endfunction

   // Pull the 32 data bits out of the non-power-of-two positions
   function automatic logic [DATA_W-1:0] ecc_data_f(input logic [CW_W-1:0] cw);
      logic [DATA_W-1:0] d;
      int k;
      d = '0;
      k = 0;
      for (int p = 1; p <= CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = cw[p-1];
            k++;
         end
      end
      return d;
   endfunction

   // Place data, then set each check bit to cancel its syndrome bit
   function automatic logic [CW_W-1:0] ecc_enc_f(input logic [DATA_W-1:0] d);
      logic [CW_W-1:0] cw;
      logic [CHK_W-1:0] s;
      int k;
      cw = '0;
      k = 0;
      for (int p = 1; p <= CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p-1] = d[k];
            k++;
         end
      end
      s = ecc_syn_f(cw);
      for (int b = 0; b < CHK_W; b++) begin
         cw[(1 << b) - 1] = s[b];
      end
      return cw;
   endfunction
endpackage
`default_nettype wire

/* File: hdl/ecc_group_fix.sv */
// Single-error corrector for one stored group codeword
`default_nettype none
module ecc_group_fix
   import eeprom_ecc_pkg::*;
(
   // Stored word from the array
   input wire logic [eeprom_ecc_pkg::CW_W-1:0] word,
   // Corrected data and status
   output logic [eeprom_ecc_pkg::DATA_W-1:0] data,
   output logic fixed,
   output logic bad
);
   // ==========================================================
   // Syndrome decode
   // ==========================================================
   logic [CHK_W-1:0] syn; // Failing position, zero when clean
   logic [CW_W-1:0] cw_fix; // Word with the failing bit flipped

   // Flip the addressed bit; a syndrome past the word means two errors
   always_comb begin
      syn = ecc_syn_f(word);
      cw_fix = word;
      fixed = 1'b0;
      bad = 1'b0;
      if (syn != '0) begin
         if (int'(syn) <= CW_W) begin
            cw_fix[int'(syn) - 1] = ~word[int'(syn) - 1];
            fixed = 1'b1;
         end else begin
            // Cannot be repaired, data passes as stored
            bad = 1'b1;
         end
      end
      data = ecc_data_f(cw_fix);
   end
endmodule
`default_nettype wire

/* File: bench/array_model.sv */
// Behavioural array: one codeword per group, read answered one cycle after the strobe
`default_nettype none
module array_model
   import eeprom_ecc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Array port
   input wire logic [eeprom_ecc_pkg::GRP_W-1:0] addr,
   input wire logic rd_en,
   output logic [eeprom_ecc_pkg::CW_W-1:0] rd_word,
   input wire logic wr_en,
   input wire logic [eeprom_ecc_pkg::CW_W-1:0] wr_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [CW_W-1:0] mem [0:(1<<GRP_W)-1]; // Stored codewords, bench may preload
   int wr_cnt = 0; // Group programs seen, the endurance budget
   // ==========================================================
   // Read and program
   // ==========================================================
   // Outside a read the word flips every cycle, so stale data cannot pass for fresh
   always @(posedge clk) begin
      rd_word <= rd_en ? mem[addr] : ~rd_word;
      if (wr_en) begin
         mem[addr] <= wr_word;
         wr_cnt <= wr_cnt + 1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/eeprom_group_ecc_tb_top.sv */
// Self-checking bench for the group ECC block
`default_nettype none
module eeprom_group_ecc_tb_top;
   import eeprom_ecc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WC = 100; // Short busy time keeps the run brief
   logic clk = 1'b0, rst = 1'b1, rd_req = 1'b0, wr_stb = 1'b0, wr_stop = 1'b0;
   logic [13:0] rd_addr = '0, wr_addr = '0;
   logic [7:0] wr_data = '0, rd_data;
   logic rd_valid, rd_fixed, busy, prog_start, a_rd, a_wr;
   logic [GRP_W-1:0] a_addr;
   logic [CW_W-1:0] a_rword, a_wword;
   logic [31:0] gold [0:31]; // Expected group contents
   logic [31:0] seed = 32'hea99;
   logic [8:0] q [$]; // Expected {fixed, byte} per read
   int fails = 0, cmp_count = 0, cyc = 0, n, w0, bc0, busy_cyc = 0;
   // Clock, 100 ns period
   always #50 clk = ~clk;
   eeprom_group_ecc #(.WRITE_CYCLES(WC)) eeprom_group_ecc_i (.CLK(clk), .RST(rst),
      .FE_RD_REQ(rd_req), .FE_RD_ADDR(rd_addr), .FE_RD_DATA(rd_data),
      .FE_RD_VALID(rd_valid), .FE_RD_FIXED(rd_fixed), .FE_WR_STB(wr_stb),
      .FE_WR_ADDR(wr_addr), .FE_WR_DATA(wr_data), .FE_WR_STOP(wr_stop), .FE_BUSY(busy),
      .PROG_START(prog_start), .ARR_ADDR(a_addr), .ARR_RD_EN(a_rd),
      .ARR_RD_WORD(a_rword), .ARR_WR_EN(a_wr), .ARR_WR_WORD(a_wword));
   array_model array_model_i (.clk(clk), .addr(a_addr), .rd_en(a_rd), .rd_word(a_rword),
      .wr_en(a_wr), .wr_word(a_wword));
   // ==========================================================
   // Helpers
   // ==========================================================
   // Xorshift source of data
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Position-sum syndrome
   function automatic logic [5:0] syn(input logic [37:0] w);
      syn = '0;
      for (int p = 1; p <= 38; p++) if (w[p-1]) syn ^= 6'(p);
   endfunction
   // Own encoder: data in non-power-of-two positions, checks cancel the syndrome
   function automatic logic [37:0] enc(input logic [31:0] d);
      int k;
      logic [5:0] s;
      k = 0;
      enc = '0;
      for (int p = 1; p <= 38; p++) if ((p & (p - 1)) != 0) enc[p-1] = d[k++];
      s = syn(enc);
      for (int b = 0; b < 6; b++) enc[(1 << b) - 1] = s[b];
   endfunction
   task automatic check(input logic [37:0] seen, input logic [37:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Raise a read and note its answer; caller lowers the request
   task automatic rd(input int a, input logic f);
      @(negedge clk);
      rd_req = 1'b1;
      rd_addr = 14'(a);
      q.push_back({f, gold[(a % 128) / 4][8 * (a % 4) +: 8]});
   endtask
   // Let an in-flight read finish before the array is touched
   task automatic idle();
      @(negedge clk);
      rd_req = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic wr(input int a, input logic [7:0] d);
      @(negedge clk);
      wr_stb = 1'b1;
      wr_addr = 14'(a);
      wr_data = d;
      gold[(a % 128) / 4][8 * (a % 4) +: 8] = d;
      @(negedge clk);
      wr_stb = 1'b0;
   endtask
   // Stop: start pulse in its own cycle, busy from the next
   task automatic stop_chk(input logic e);
      @(negedge clk);
      wr_stop = 1'b1;
      #10 check(38'(prog_start), 38'(e));
      @(negedge clk);
      wr_stop = 1'b0;
      check(38'(busy), 38'(e));
   endtask
   // Busy length, bounded so a stuck flag cannot hang the run
   task automatic wait_idle();
      n = 0;
      while (busy === 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
   endtask
   // ==========================================================
   // Answer monitor and hang guard
   // ==========================================================
   always @(negedge clk) begin
      // Busy cycles counted from the very first, whatever the main sequence is doing
      if (busy === 1'b1) busy_cyc++;
      if (rd_valid === 1'b1) begin
         if (q.size() == 0) check(38'h1, 38'h0);
         else check(38'({rd_fixed, rd_data}), 38'(q.pop_front()));
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      for (int g = 0; g < 32; g++) begin
         gold[g] = rnd();
         array_model_i.mem[g] = enc(gold[g]);
      end
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (20000) @(negedge clk);
      // Back-to-back lanes of two groups
      for (int a = 0; a < 8; a++) rd(a, 1'b0);
      idle();
      // Each of the 38 stored bits flipped in turn is repaired
      for (int b = 0; b < 38; b++) begin
         array_model_i.mem[2] = enc(gold[2]) ^ (38'h1 << b);
         rd(8 + b % 4, 1'b1);
         idle();
      end
      // One byte into a group with a damaged neighbour; requests while busy are dropped
      array_model_i.mem[1] = enc(gold[1]) ^ 38'h4;
      w0 = array_model_i.wr_cnt;
      wr(6, 8'(rnd()));
      bc0 = busy_cyc;
      stop_chk(1'b1);
      rd_req = 1'b1;
      wr_stb = 1'b1;
      repeat (3) @(negedge clk);
      rd_req = 1'b0;
      wr_stb = 1'b0;
      wait_idle();
      check(38'(busy_cyc - bc0 >= WC), 38'h1);
      check(38'(array_model_i.wr_cnt - w0), 38'h1);
      check(array_model_i.mem[1], enc(gold[1]));
      for (int a = 4; a < 8; a++) rd(a, 1'b0);
      idle();
      // Stop with nothing stored programs nothing
      stop_chk(1'b0);
      // Page write touching two groups: one cycle, two group programs
      w0 = array_model_i.wr_cnt;
      wr(12, 8'(rnd()));
      wr(127, 8'(rnd()));
      stop_chk(1'b1);
      wait_idle();
      check(38'(array_model_i.wr_cnt - w0), 38'h2);
      check(array_model_i.mem[31], enc(gold[31]));
      rd(12, 1'b0);
      rd(127, 1'b0);
      idle();
      check(38'(q.size()), 38'h0);
      conclude();
   end
endmodule
`default_nettype wire
